// *** sar_adc_model.sv ***
// Purpose: Behavioural converter on the far side of the controller
// Assumes: Pins sampled on clk; conversion takes a few cycles
// Notes: Starts powered, a simplification of the power-up state
`timescale 1ns/100ps
module sar_adc_model (
  input wire clk,
  input wire nrst,
  input wire conversion_start_n,
  input wire device_select_n,
  input wire read_strobe_n,
  input wire [2:0] channel_select_bits,
  input wire slow_conv,
  output reg conversion_done_n,
  output wire [7:0] data_in,
  output reg pwr_on
);
  reg [7:0] hold_reg;
  reg [7:0] res_reg;
  reg [2:0] cnt_reg;
  reg [2:0] mux_reg;
  reg start_d;
  reg rd_d;
  // Released bus shows inverse so stale data never matches
  assign data_in = (!device_select_n && !read_strobe_n) ? res_reg : ~res_reg;
  // Conversion, done pulse and power state
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      conversion_done_n <= 1'b1;
      pwr_on <= 1'b1;
      {hold_reg, res_reg, cnt_reg, mux_reg} <= 22'h0;
      {start_d, rd_d} <= 2'h3;
    end
    else
    begin
      start_d <= conversion_start_n;
      rd_d <= read_strobe_n;
      if (rd_d && !read_strobe_n)
        mux_reg <= channel_select_bits;
      // Start alone runs a conversion; no other control needed
      if (start_d && !conversion_start_n && pwr_on)
      begin
        hold_reg <= {mux_reg, 5'h0B};
        // Slow mode lets done fall after start has risen, unless power-down mode holds start low
        cnt_reg <= slow_conv ? 3'h7 : 3'h5;
      end
      else if (cnt_reg != 3'h0)
        cnt_reg <= cnt_reg - 3'h1;
      if (cnt_reg == 3'h3)
      begin
        conversion_done_n <= 1'b0;
        res_reg <= hold_reg;
      end
      // Two cycles low is 100 ns, inside the limit
      if (!conversion_done_n && (cnt_reg == 3'h1 || (!rd_d && read_strobe_n)))
      begin
        conversion_done_n <= 1'b1;
        pwr_on <= conversion_start_n;
      end
      else if (!start_d && conversion_start_n)
        pwr_on <= 1'b1;
    end
endmodule // sar_adc_model

// *** sar_fifo.v ***
// Purpose: Small result FIFO between readout and consumer
// Assumes: Single clock, synchronous inputs
// Notes: Width and depth are parameters; depth a power of two
`timescale 1ns/100ps
module sar_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;
  assign in_ready = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  // Storage has no reset; only pointers and fill count need one
  always @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end
  // Pointer and fill count
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule // sar_fifo

// *** sar_host_ctrl.v ***
// Purpose: Host controller that starts conversions and reads results
// Assumes: Converter pins synchronous to clk; one clock domain
// Notes: Results with their channel go through a 4-word FIFO
// Notes: One conversion at a time; the next go waits for busy low
// Notes: A refused go leaves every pin at its idle level
`timescale 1ns/100ps
`include "sar_regs.vh"
////////////////////////////////////////////////////////////////////////////
module sar_host_ctrl (
  input wire clk,
  input wire nrst,
  input wire go,
  input wire [2:0] chan,
  input wire power_down_mode,
  output reg busy_reg,
  output reg conversion_start_n,
  output reg device_select_n,
  output reg read_strobe_n,
  output reg [2:0] channel_select_bits,
  input wire conversion_done_n,
  input wire [7:0] data_in,
  output reg res_valid_reg,
  input wire res_ready,
  output reg [7:0] res_data_reg,
  output reg [2:0] res_chan_reg
);
  ////////////////////////////////////////////////////////////////////////
  // Sequencer state codes
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_READ = 3'd3;
  localparam ST_REACQ = 3'd4;
  localparam ST_RISE = 3'd5;
  // Pin timing counts in sequencer cycles
  localparam [3:0] START_LOW = 4'd`SAR_START_LOW_CYC;
  localparam [3:0] READ_LOW = 4'd`SAR_READ_LOW_CYC;
  localparam [3:0] REACQ_WAIT = 4'd`SAR_REACQ_CYC;
  // Sequence state and copies of the request
  reg [2:0] state_reg;
  reg [3:0] cnt_reg;
  reg done_d_reg;
  reg [2:0] next_chan_reg;
  reg pd_reg;
  // FIFO and output stage wiring
  wire f_in_ready;
  wire f_out_valid;
  wire [10:0] f_out_data;
  wire out_take;
  wire done_fall;
  wire capture;
  ////////////////////////////////////////////////////////////////////////
  // Edge detect on the done pin, treated as an interrupt edge
  assign done_fall = done_d_reg && !conversion_done_n;
  // Sample only on the last low cycle of a read; the early path enters
  // the read state with the strobe still high and the count at zero
  assign capture = (state_reg == ST_READ) && (cnt_reg == 4'd0) &&
    !read_strobe_n;
  // Output stage takes a word when empty or being emptied
  assign out_take = !res_valid_reg || res_ready;
  ////////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Pins idle; done seen high so no false edge after reset
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      done_d_reg <= 1'b1;
      busy_reg <= 1'b0;
      conversion_start_n <= 1'b1;
      device_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      channel_select_bits <= 3'h0;
      next_chan_reg <= 3'h0;
      pd_reg <= 1'b0;
    end
    else
    begin
      // Done sampled every cycle for edge detection
      done_d_reg <= conversion_done_n;
      case (state_reg)
        ST_IDLE:
        begin
          // Back-pressure: no new conversion while FIFO is full
          if (go && f_in_ready)
          begin
            busy_reg <= 1'b1;
            // Channel and mode held for the whole sequence
            next_chan_reg <= chan;
            pd_reg <= power_down_mode;
            conversion_start_n <= 1'b0;
            cnt_reg <= START_LOW;
            state_reg <= ST_START;
          end
        end
        ST_START:
        begin
          // Low-power mode keeps start low past the done rise
          if (cnt_reg != 4'd0)
            cnt_reg <= cnt_reg - 1'b1;
          else
          begin
            if (!pd_reg)
              conversion_start_n <= 1'b1;
            state_reg <= ST_WAIT;
          end
          // A short conversion may end while start is still low
          if (done_fall)
            state_reg <= ST_READ;
        end
        ST_WAIT:
        begin
          // Done pulse may last only one 50 ns cycle; edge caught anyway
          if (done_fall)
          begin
            // Select and read drop together; channel rides with them
            // Reading on the done edge is the tied-strobe scheme
            device_select_n <= 1'b0;
            read_strobe_n <= 1'b0;
            channel_select_bits <= next_chan_reg;
            cnt_reg <= READ_LOW;
            state_reg <= ST_READ;
          end
        end
        ST_READ:
        begin
          if (read_strobe_n)
          begin
            // Came from ST_START early; open the strobe now
            device_select_n <= 1'b0;
            read_strobe_n <= 1'b0;
            channel_select_bits <= next_chan_reg;
            cnt_reg <= READ_LOW;
          end
          // Strobe held low for the read width
          else if (cnt_reg != 4'd0)
            cnt_reg <= cnt_reg - 1'b1;
          else
          begin
            // Read rise also cuts a done pulse short
            device_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            cnt_reg <= REACQ_WAIT;
            state_reg <= ST_REACQ;
          end
        end
        ST_REACQ:
        begin
          // Hold off next start for track-and-hold
          if (cnt_reg != 4'd0)
            cnt_reg <= cnt_reg - 1'b1;
          else
            state_reg <= ST_RISE;
        end
        ST_RISE:
        begin
          // Rising start wakes a powered-down part
          // Busy drops with start, so the next go meets a rested hold
          conversion_start_n <= 1'b1;
          busy_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        // Unused codes fall back to idle
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Result FIFO; holds data with the channel it was read on
  sar_fifo #(
    .WIDTH(11),
    .DEPTH(`SAR_FIFO_DEPTH),
    .AW(2)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(capture),
    .in_ready(f_in_ready),
    .in_data({channel_select_bits, data_in}),
    .out_valid(f_out_valid),
    .out_ready(out_take),
    .out_data(f_out_data)
  );
  ////////////////////////////////////////////////////////////////////////
  // Output stage registers so ports come from flops
  // out_take keeps this stage and the FIFO pop in step
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      res_valid_reg <= 1'b0;
      res_data_reg <= 8'h00;
      res_chan_reg <= 3'h0;
    end
    else if (out_take)
    begin
      res_valid_reg <= f_out_valid;
      if (f_out_valid)
      begin
        res_data_reg <= f_out_data[7:0];
        res_chan_reg <= f_out_data[10:8];
      end
    end
  end
endmodule // sar_host_ctrl

// *** sar_host_monitor.sv ***
// Purpose: Pin protocol checks for the host controller
// Assumes: One clock, async active-low reset
// Notes: Bound from the testbench top file
`timescale 1ns/100ps
module sar_host_monitor (
  input wire clk,
  input wire nrst,
  input wire conversion_start_n,
  input wire device_select_n,
  input wire read_strobe_n,
  input wire [2:0] channel_select_bits,
  input wire conversion_done_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Hold stage needs time to reacquire before a new start
  a_reacq_gap: assert property (
    $rose(read_strobe_n) |=> !$fell(conversion_start_n) [*2])
    else $error("start too soon after read");
  // Channel lines must not move inside a read
  a_chan_hold: assert property (
    !read_strobe_n && !$fell(read_strobe_n) |-> $stable(channel_select_bits))
    else $error("channel moved during read");
  a_sel_with_rd: assert property (
    !read_strobe_n |-> !device_select_n)
    else $error("read without select");
  // Done edge acts as the result-ready event
  a_read_on_done: assert property (
    $fell(conversion_done_n) |-> ##[1:4] !read_strobe_n)
    else $error("no read after done");
  a_read_width: assert property (
    $fell(read_strobe_n) |-> !read_strobe_n [*3] ##1 read_strobe_n)
    else $error("read width wrong");
  c_sleep: cover property ($rose(conversion_done_n) && !conversion_start_n);
  c_awake: cover property ($rose(conversion_done_n) && conversion_start_n);
  c_read: cover property ($fell(read_strobe_n));
endmodule // sar_host_monitor

// *** sar_regs.vh ***
// Purpose: Constants for the host-side converter readout controller
// Assumes: 20 MHz clock, period 50 ns
// Notes: Times in ns; cycle counts derived from them
`ifndef SAR_REGS_VH
`define SAR_REGS_VH
`define SAR_CLK_PERIOD_NS 50
// Reacquire time after a read, least time
`define SAR_REACQ_NS 30
// Same time in whole clock cycles, rounded up
`define SAR_REACQ_CYC 1
// Longest done pulse from the converter
`define SAR_DONE_MAX_NS 110
// Start low count for a conversion; outside power-down mode start stays low one cycle more than this
`define SAR_START_LOW_CYC 4
// Read strobe low count; strobe stays low one cycle more than this
`define SAR_READ_LOW_CYC 2
`define SAR_DATA_W 8
`define SAR_CHAN_W 3
`define SAR_FIFO_DEPTH 4
`endif

// *** tb_sar_host.sv ***
// Purpose: Self-checking bench for the host readout controller
// Assumes: Inputs driven 5 ns after rising edge
// Notes: Expected byte is channel of the previous read
`timescale 1ns/100ps
module tb;
  reg clk, nrst, go, power_down_mode, res_ready, rd_pwr, slow_conv;
  reg [2:0] chan, prev_ch;
  wire busy_reg, conversion_start_n, device_select_n, read_strobe_n;
  wire conversion_done_n, res_valid_reg, pwr_on;
  wire [2:0] channel_select_bits, res_chan_reg;
  wire [7:0] data_in, res_data_reg;
  integer num_errors, checked, cycles;
  sar_host_ctrl DUT (.clk(clk), .nrst(nrst), .go(go), .chan(chan),
    .power_down_mode(power_down_mode), .busy_reg(busy_reg),
    .conversion_start_n(conversion_start_n),
    .device_select_n(device_select_n), .read_strobe_n(read_strobe_n),
    .channel_select_bits(channel_select_bits),
    .conversion_done_n(conversion_done_n), .data_in(data_in),
    .res_valid_reg(res_valid_reg), .res_ready(res_ready),
    .res_data_reg(res_data_reg), .res_chan_reg(res_chan_reg));
  sar_adc_model u_adc (.clk(clk), .nrst(nrst), .slow_conv(slow_conv),
    .conversion_start_n(conversion_start_n),
    .device_select_n(device_select_n), .read_strobe_n(read_strobe_n),
    .channel_select_bits(channel_select_bits),
    .conversion_done_n(conversion_done_n), .data_in(data_in),
    .pwr_on(pwr_on));
  // Power state seen by the converter while a read is under way
  always @(posedge clk)
    if (!read_strobe_n)
      rd_pwr <= pwr_on;
  // Cut a hang short
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task check(input [10:0] seen, input [10:0] exp, input string name);
    begin
      checked = checked + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Request one conversion; ok tells whether it was taken
  task start_go(input [2:0] ch, output reg ok);
    integer n;
    begin
      @(posedge clk);
      #5 go = 1'b1;
      chan = ch;
      for (n = 0; n < 20 && busy_reg !== 1'b1; n = n + 1)
        @(posedge clk) #5;
      ok = (busy_reg === 1'b1);
      go = 1'b0;
      for (n = 0; n < 100 && busy_reg !== 1'b0; n = n + 1)
        @(posedge clk) #5;
    end
  endtask
  task get_res(input [2:0] ch);
    integer n;
    begin
      for (n = 0; n < 100 && res_valid_reg !== 1'b1; n = n + 1)
        @(posedge clk) #5;
      check(res_data_reg, {prev_ch, 5'h0B}, "data");
      check(res_chan_reg, ch, "chan");
      prev_ch = ch;
      res_ready = 1'b1;
      @(posedge clk) #5 res_ready = 1'b0;
    end
  endtask
  task test_mode1;
    integer i;
    reg ok;
    begin
      power_down_mode = 1'b0;
      for (i = 0; i < 8; i = i + 1)
      begin
        start_go(i, ok);
        check(ok, 1'b1, "accept");
        check(rd_pwr, 1'b1, "awake");
        get_res(i);
      end
      $display("test_mode1 done");
    end
  endtask
  task test_mode2;
    reg ok;
    begin
      power_down_mode = 1'b1;
      start_go(3'h5, ok);
      check(rd_pwr, 1'b0, "asleep");
      repeat (2) @(posedge clk);
      #5 check(pwr_on, 1'b1, "wake");
      get_res(3'h5);
      start_go(3'h2, ok);
      get_res(3'h2);
      $display("test_mode2 done");
    end
  endtask
  // Fill the result buffer until a request is refused
  task test_full;
    integer i, acc;
    reg ok;
    begin
      power_down_mode = 1'b0;
      slow_conv = 1'b1;
      acc = 0;
      for (i = 0; i < 6; i = i + 1)
      begin
        start_go(i, ok);
        acc = acc + ok;
      end
      // One word in the output stage plus four in the FIFO
      check(acc, 5, "accepted");
      for (i = 0; i < acc; i = i + 1)
        get_res(i);
      check(res_valid_reg, 1'b0, "empty");
      $display("test_full done");
    end
  endtask
  task complete_run;
    begin
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    {nrst, go, power_down_mode, res_ready, slow_conv, chan, prev_ch} = 11'h0;
    {num_errors, checked, cycles} = 96'h0;
    repeat (12) @(posedge clk);
    #5 nrst = 1'b1;
    test_mode1;
    test_mode2;
    test_full;
    complete_run;
  end
endmodule // tb
bind sar_host_ctrl sar_host_monitor u_mon (.clk(clk), .nrst(nrst),
  .conversion_start_n(conversion_start_n),
  .device_select_n(device_select_n), .read_strobe_n(read_strobe_n),
  .channel_select_bits(channel_select_bits),
  .conversion_done_n(conversion_done_n));
